// file: inc/smc_pkg.sv
/*
 * constants for the scalar motor curve block: register offsets, reset values,
 * option bit positions, scaling and curve limits.
 * assumes speeds in rpm, voltages in 0.1 % of full scale (1000 = 100.0 %).
 */
package smc_pkg;

	// ----------------------------------------
	// register offsets (word index)
	// ----------------------------------------
	localparam logic [4:0] SMC_OPTION_BITS = 5'h00; // motor_control_option_bits
	localparam logic [4:0] SMC_SPD_LO = 5'h01; // speed_ref_lower_limit
	localparam logic [4:0] SMC_SPD_HI = 5'h02; // speed_ref_upper_limit
	localparam logic [4:0] SMC_BOOST_V = 5'h03; // zero_freq_boost_voltage
	localparam logic [4:0] SMC_MAX_V = 5'h04; // curve_max_voltage
	localparam logic [4:0] SMC_MID_V = 5'h05; // curve_mid_voltage
	localparam logic [4:0] SMC_LOW_V = 5'h06; // curve_low_voltage
	localparam logic [4:0] SMC_FW_SPD = 5'h07; // field_weaken_start_speed
	localparam logic [4:0] SMC_MID_SPD = 5'h08; // curve_mid_speed
	localparam logic [4:0] SMC_LOW_SPD = 5'h09; // curve_low_speed
	localparam logic [4:0] SMC_SW_FREQ = 5'h0A; // switching_freq_setting
	localparam logic [4:0] SMC_CTL_TYPE = 5'h0B; // control_type_select
	localparam logic [4:0] SMC_STATUS = 5'h0C; // live status, read only
	localparam logic [4:0] SMC_IRQ_STAT = 5'h0D; // sticky events, read only
	localparam logic [4:0] SMC_IRQ_CLR = 5'h0E; // write one to clear, write only
	localparam logic [4:0] SMC_IRQ_EN = 5'h0F; // interrupt enable
	localparam logic [4:0] SMC_OUT_V = 5'h10; // applied voltage amplitude
	localparam logic [4:0] SMC_OUT_SPD = 5'h11; // applied output speed

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] SMC_OPTION_RST = 16'h000B;
	localparam logic [15:0] SMC_OPTION_MASK = 16'h000F;
	localparam logic [15:0] SMC_SPD_LO_RST = 16'h005A; // 90 rpm
	localparam logic [15:0] SMC_SPD_HI_RST = 16'h0708; // 1800 rpm
	localparam logic [15:0] SMC_BOOST_V_RST = 16'h0000;
	localparam logic [15:0] SMC_MAX_V_RST = 16'h03E8; // 100.0 %
	localparam logic [15:0] SMC_MID_V_RST = 16'h029B; // 66.7 %
	localparam logic [15:0] SMC_LOW_V_RST = 16'h014D; // 33.3 %
	localparam logic [15:0] SMC_FW_SPD_RST = 16'h0708; // 1800 rpm
	localparam logic [15:0] SMC_MID_SPD_RST = 16'h04B0; // 1200 rpm
	localparam logic [15:0] SMC_LOW_SPD_RST = 16'h0258; // 600 rpm
	localparam logic [15:0] SMC_SW_FREQ_RST = 16'h0032; // 5.0 kHz in 0.1 kHz
	localparam logic [15:0] SMC_CTL_TYPE_RST = 16'h0000; // scalar
	localparam logic [15:0] SMC_CTL_VECTOR = 16'h0003; // first non-scalar code

	// ----------------------------------------
	// option bits
	// ----------------------------------------
	localparam int SMC_OPT_SLIP_REGEN = 0;
	localparam int SMC_OPT_DEADTIME = 1;
	localparam int SMC_OPT_STAB = 2;
	localparam int SMC_OPT_OT_REDUCE = 3;

	// ----------------------------------------
	// interrupt / status bits
	// ----------------------------------------
	localparam int SMC_EV_CFG_ERR = 0;
	localparam int SMC_EV_PFB_FAULT = 1;
	localparam int SMC_EV_OT_REDUCE = 2;
	localparam int SMC_EV_W = 3;

	// ----------------------------------------
	// scaling and limits
	// ----------------------------------------
	localparam logic [15:0] SMC_FULL_V = 16'h03E8; // 100.0 %
	localparam int SMC_RPM_PER_HZ = 30; // 4-pole machine
	localparam int SMC_CUT_FREQ_DHZ = 1; // pwm cut below 0.1 Hz
	localparam int SMC_SLOPE_MAX_PM_HZ = 100; // 10.0 %/Hz in 0.1 % units
	localparam int SMC_STAB_SHIFT = 3; // damping gain 1/8

endpackage : smc_pkg

// file: rtl/smc_core.sv
/*
 * scalar motor curve control: limited speed reference mapped through a
 * five-point voltage/frequency curve, option bits for compensations, config
 * check, pwm cut and interrupt logic, plus the register port.
 * assumes pins regen, overtemp, dc brake and pulse feedback are asynchronous;
 * speed_ref and compensation inputs come from logic on clk.
 */
// Design decisions made here: the address-and-strobe port and the register offsets.
//
// Behaviour
// (R1) four-bit option word, reset value 0xB
// (R2) regen without bit 0 drops slip compensation
// (R3) bit 1 enables dead-time distortion correction
// (R4) dead-time off also blocks pulse feedback fault
// (R5) bit 2 enables output current damping loop
// (R6) bit 3 lowers switching frequency on overtemp
// (R7) clamp speed reference between lower/upper limits
// (R8) five-point curve gives voltage amplitude
// (R9) above field-weakening speed voltage holds full
// (R10) flag config error on order or slope
// (R11) cut pwm below 0.1 Hz unless braking
// (R12) default curve straight line to rated point
// (R13) default mode is scalar control
// (R14) linear interpolation between adjacent curve points
`timescale 1ns/10ps

module smc_core
	import smc_pkg::*;
#(
	parameter int RPM_PER_HZ = SMC_RPM_PER_HZ
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [4:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// asynchronous pins
	input wire logic regen,
	input wire logic switch_overtemp_alarm,
	input wire logic dc_braking,
	input wire logic pulse_feedback_bad,
	// same-clock inputs
	input wire logic [15:0] speed_ref,
	input wire logic signed [15:0] slip_comp_in,
	input wire logic signed [15:0] deadtime_err,
	input wire logic signed [15:0] current_osc,
	// drive outputs
	output logic [15:0] volt_amp,
	output logic [15:0] out_speed,
	output logic pwm_enable,
	output logic signed [15:0] deadtime_corr,
	output logic signed [15:0] stab_corr,
	output logic [15:0] sw_freq_eff,
	output logic scalar_active,
	// status
	output logic pulse_feedback_fault,
	output logic config_error_status,
	output logic irq
);

	// ----------------------------------------
	// derived limits
	// ----------------------------------------
	// least pwm frequency in rpm, rounded up
	localparam logic [15:0] CUT_RPM = 16'((SMC_CUT_FREQ_DHZ * RPM_PER_HZ + 9) / 10);
	localparam logic [35:0] RPH = 36'(RPM_PER_HZ);
	localparam logic [35:0] SLOPE_MAX = 36'(SMC_SLOPE_MAX_PM_HZ);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [3:0] motor_control_option_bits; // compensation options
	logic [15:0] speed_ref_lower_limit, speed_ref_upper_limit; // reference window
	logic [15:0] zero_freq_boost_voltage, curve_max_voltage, curve_mid_voltage, curve_low_voltage;
	logic [15:0] field_weaken_start_speed, curve_mid_speed, curve_low_speed; // curve speeds
	logic [15:0] switching_freq_setting, control_type_select;
	logic [SMC_EV_W-1:0] irq_stat, irq_en; // sticky events, enables

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [3:0] pin_s1; // first stage, read only by pin_s2
	logic [3:0] pin_s2; // usable pin levels
	logic regen_s, overtemp_s, brake_s, pfb_bad_s; // synced pin levels

	// two flops for each asynchronous pin
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
		end
		else
		begin
			pin_s1 <= {pulse_feedback_bad, dc_braking, switch_overtemp_alarm, regen};
			pin_s2 <= pin_s1;
		end
	end

	assign {pfb_bad_s, brake_s, overtemp_s, regen_s} = pin_s2;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// magnitude of a voltage step
	function automatic logic [15:0] smc_absdiff(input logic [15:0] a, input logic [15:0] b);
		smc_absdiff = (a > b) ? a - b : b - a;
	endfunction : smc_absdiff

	// segment steeper than the slope limit
	function automatic logic smc_too_steep(input logic [15:0] dv, input logic [15:0] dn);
		smc_too_steep = (36'(dv) * RPH) > (SLOPE_MAX * 36'(dn));
	endfunction : smc_too_steep

	// signed sum saturated to an unsigned word
	function automatic logic [15:0] smc_sat(input logic [15:0] a, input logic signed [15:0] b);
		logic signed [17:0] s;
		s = $signed({2'b00, a}) + 18'(b);
		if (s < 0)
			smc_sat = 16'h0000;
		else if (s > 18'sh0FFFF)
			smc_sat = 16'hFFFF;
		else
			smc_sat = s[15:0];
	endfunction : smc_sat

	// ----------------------------------------
	// curve evaluation
	// ----------------------------------------
	logic [15:0] spd_lim; // clamped reference
	logic [1:0] seg; // active segment
	logic seg_flat; // field-weakening region
	logic [15:0] seg_x0, seg_x1, seg_y0, seg_y1; // segment end points
	logic [15:0] interp_v, next_volt_amp;

	// clamp to the configured speed window [R7]
	assign spd_lim = (speed_ref < speed_ref_lower_limit) ? speed_ref_lower_limit :
		(speed_ref > speed_ref_upper_limit) ? speed_ref_upper_limit : speed_ref;

	// pick the segment holding the speed [R8]
	assign seg_flat = spd_lim >= field_weaken_start_speed;
	assign seg = (spd_lim < curve_low_speed) ? 2'd0 : (spd_lim < curve_mid_speed) ? 2'd1 : 2'd2;
	assign seg_x0 = (seg == 2'd0) ? 16'h0000 : (seg == 2'd1) ? curve_low_speed : curve_mid_speed;
	assign seg_x1 = (seg == 2'd0) ? curve_low_speed : (seg == 2'd1) ? curve_mid_speed : field_weaken_start_speed;
	assign seg_y0 = (seg == 2'd0) ? zero_freq_boost_voltage : (seg == 2'd1) ? curve_low_voltage : curve_mid_voltage;
	assign seg_y1 = (seg == 2'd0) ? curve_low_voltage : (seg == 2'd1) ? curve_mid_voltage : curve_max_voltage;

	// straight line between neighbouring points [R14]
	smc_interp u_interp (
		.x(spd_lim),
		.x0(seg_x0),
		.x1(seg_x1),
		.y0(seg_y0),
		.y1(seg_y1),
		.y(interp_v)
	);

	// full amplitude from the field-weakening point upward [R9]
	assign next_volt_amp = seg_flat ? SMC_FULL_V : interp_v;

	// ----------------------------------------
	// configuration check
	// ----------------------------------------
	logic order_bad, slope_bad; // points out of order, segment too steep
	logic next_cfg_err;

	assign order_bad = (curve_low_speed >= curve_mid_speed) || (curve_mid_speed >= field_weaken_start_speed);
	assign slope_bad = smc_too_steep(smc_absdiff(curve_low_voltage, zero_freq_boost_voltage), curve_low_speed)
		|| smc_too_steep(smc_absdiff(curve_mid_voltage, curve_low_voltage), curve_mid_speed - curve_low_speed)
		|| smc_too_steep(smc_absdiff(curve_max_voltage, curve_mid_voltage),
			field_weaken_start_speed - curve_mid_speed)
		|| smc_too_steep(smc_absdiff(SMC_FULL_V, curve_max_voltage),
			speed_ref_upper_limit - field_weaken_start_speed);
	assign next_cfg_err = order_bad || slope_bad; // [R10]

	// ----------------------------------------
	// compensations and options
	// ----------------------------------------
	logic slip_on, dt_on, ot_reduce; // slip applied, dead-time on, frequency cut
	logic [15:0] next_out_speed;
	logic next_pwm_en;

	// in regeneration slip is kept only with bit 0 set [R2]
	assign slip_on = !regen_s || motor_control_option_bits[SMC_OPT_SLIP_REGEN];
	assign next_out_speed = smc_sat(spd_lim, slip_on ? slip_comp_in : 16'sh0000);
	assign dt_on = motor_control_option_bits[SMC_OPT_DEADTIME]; // [R3]
	assign ot_reduce = overtemp_s && motor_control_option_bits[SMC_OPT_OT_REDUCE]; // [R6]
	// pwm stops below the least frequency, braking overrides [R11]
	assign next_pwm_en = (next_out_speed >= CUT_RPM) || brake_s;

	// ----------------------------------------
	// register port decode
	// ----------------------------------------
	logic [SMC_EV_W-1:0] events, clr_mask; // one-cycle event pulses, clear bits
	logic cfg_err_q, ot_reduce_q; // last states for edge detection
	logic [15:0] next_rdata, status_word;

	assign clr_mask = (wr && addr == SMC_IRQ_CLR) ? wdata[SMC_EV_W-1:0] : '0;
	assign events[SMC_EV_CFG_ERR] = next_cfg_err && !cfg_err_q;
	// fault only raised while compensation is on [R4]
	assign events[SMC_EV_PFB_FAULT] = pfb_bad_s && dt_on && !pulse_feedback_fault;
	assign events[SMC_EV_OT_REDUCE] = ot_reduce && !ot_reduce_q;
	assign status_word = {10'h000, scalar_active, pwm_enable, ot_reduce_q, regen_s,
		pulse_feedback_fault, config_error_status};

	always_comb
	begin
		unique case (addr)
			SMC_OPTION_BITS: next_rdata = {12'h000, motor_control_option_bits};
			SMC_SPD_LO: next_rdata = speed_ref_lower_limit;
			SMC_SPD_HI: next_rdata = speed_ref_upper_limit;
			SMC_BOOST_V: next_rdata = zero_freq_boost_voltage;
			SMC_MAX_V: next_rdata = curve_max_voltage;
			SMC_MID_V: next_rdata = curve_mid_voltage;
			SMC_LOW_V: next_rdata = curve_low_voltage;
			SMC_FW_SPD: next_rdata = field_weaken_start_speed;
			SMC_MID_SPD: next_rdata = curve_mid_speed;
			SMC_LOW_SPD: next_rdata = curve_low_speed;
			SMC_SW_FREQ: next_rdata = switching_freq_setting;
			SMC_CTL_TYPE: next_rdata = control_type_select;
			SMC_STATUS: next_rdata = status_word;
			SMC_IRQ_STAT: next_rdata = {13'h0000, irq_stat};
			SMC_IRQ_EN: next_rdata = {13'h0000, irq_en};
			SMC_OUT_V: next_rdata = volt_amp;
			SMC_OUT_SPD: next_rdata = out_speed;
			default: next_rdata = 16'h0000; // unmapped and write-only read zero
		endcase
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// defaults give a straight line from boost to rated point [R12]
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			motor_control_option_bits <= SMC_OPTION_RST[3:0]; // [R1]
			speed_ref_lower_limit <= SMC_SPD_LO_RST;
			speed_ref_upper_limit <= SMC_SPD_HI_RST;
			zero_freq_boost_voltage <= SMC_BOOST_V_RST;
			curve_max_voltage <= SMC_MAX_V_RST;
			curve_mid_voltage <= SMC_MID_V_RST;
			curve_low_voltage <= SMC_LOW_V_RST;
			field_weaken_start_speed <= SMC_FW_SPD_RST;
			curve_mid_speed <= SMC_MID_SPD_RST;
			curve_low_speed <= SMC_LOW_SPD_RST;
			switching_freq_setting <= SMC_SW_FREQ_RST;
			control_type_select <= SMC_CTL_TYPE_RST; // [R13]
			irq_en <= '0;
		end
		else if (wr)
		begin
			unique case (addr)
				SMC_OPTION_BITS: motor_control_option_bits <= wdata[3:0]; // [R1]
				SMC_SPD_LO: speed_ref_lower_limit <= wdata;
				SMC_SPD_HI: speed_ref_upper_limit <= wdata;
				SMC_BOOST_V: zero_freq_boost_voltage <= wdata;
				SMC_MAX_V: curve_max_voltage <= wdata;
				SMC_MID_V: curve_mid_voltage <= wdata;
				SMC_LOW_V: curve_low_voltage <= wdata;
				SMC_FW_SPD: field_weaken_start_speed <= wdata;
				SMC_MID_SPD: curve_mid_speed <= wdata;
				SMC_LOW_SPD: curve_low_speed <= wdata;
				SMC_SW_FREQ: switching_freq_setting <= wdata;
				SMC_CTL_TYPE: control_type_select <= wdata;
				SMC_IRQ_EN: irq_en <= wdata[SMC_EV_W-1:0];
				default: ; // read-only, clear and unmapped words
			endcase
		end
	end

	// ----------------------------------------
	// sticky status and interrupt
	// ----------------------------------------
	// set beats clear so an event in the clearing cycle survives
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			irq_stat <= '0;
			irq <= 1'b0;
			cfg_err_q <= 1'b0;
			ot_reduce_q <= 1'b0;
		end
		else
		begin
			irq_stat <= (irq_stat & ~clr_mask) | events;
			irq <= |(((irq_stat & ~clr_mask) | events) & irq_en);
			cfg_err_q <= next_cfg_err;
			ot_reduce_q <= ot_reduce;
		end
	end

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	// outputs all flopped so the bridge sees one settled set per cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata <= 16'h0000;
			volt_amp <= 16'h0000;
			out_speed <= 16'h0000;
			pwm_enable <= 1'b0;
			deadtime_corr <= 16'sh0000;
			stab_corr <= 16'sh0000;
			sw_freq_eff <= SMC_SW_FREQ_RST;
			scalar_active <= 1'b1;
			pulse_feedback_fault <= 1'b0;
			config_error_status <= 1'b0;
		end
		else
		begin
			rdata <= rd ? next_rdata : 16'h0000;
			volt_amp <= next_volt_amp; // [R8]
			out_speed <= next_out_speed; // [R2]
			pwm_enable <= next_pwm_en; // [R11]
			deadtime_corr <= dt_on ? deadtime_err : 16'sh0000; // [R3]
			// damping opposes the oscillating part of the current [R5]
			stab_corr <= motor_control_option_bits[SMC_OPT_STAB] ? -(current_osc >>> SMC_STAB_SHIFT) : 16'sh0000;
			// halve the switching frequency while hot [R6]
			sw_freq_eff <= ot_reduce ? (switching_freq_setting >> 1) : switching_freq_setting;
			scalar_active <= control_type_select < SMC_CTL_VECTOR; // [R13]
			// fault latches while compensation is on, cleared when it goes off [R4]
			pulse_feedback_fault <= dt_on && (pulse_feedback_fault || pfb_bad_s);
			config_error_status <= next_cfg_err; // [R10]
		end
	end

endmodule : smc_core

// file: rtl/smc_interp.sv
/*
 * linear interpolation between two curve points, combinational.
 * assumes x0 <= x <= x1; a zero-length segment returns y1.
 */
`timescale 1ns/10ps

module smc_interp
	import smc_pkg::*;
(
	// segment input
	input wire logic [15:0] x,
	input wire logic [15:0] x0,
	input wire logic [15:0] x1,
	input wire logic [15:0] y0,
	input wire logic [15:0] y1,
	// result
	output logic [15:0] y
);

	// ----------------------------------------
	// arithmetic
	// ----------------------------------------
	logic signed [16:0] dy; // rise of segment
	logic [15:0] dx; // run of segment
	logic [15:0] px; // position into segment
	logic signed [33:0] prod; // rise times position
	logic signed [33:0] quot; // scaled rise
	logic signed [17:0] sum; // y0 plus scaled rise

	assign dy = $signed({1'b0, y1}) - $signed({1'b0, y0});
	assign dx = x1 - x0;
	assign px = x - x0;
	assign prod = 34'(dy) * $signed({18'h00000, px});
	// division sits in one cycle; fine at 100 MHz only with retiming margin
	assign quot = (dx == 16'h0000) ? 34'(dy) : prod / $signed({18'h00000, dx});
	assign sum = 18'($signed({2'b00, y0}) + quot[17:0]);
	assign y = (sum < 0) ? 16'h0000 : sum[15:0];

endmodule : smc_interp

// file: testbench/smc_bridge_model.sv
/*
 * behavioural power bridge on the far side of smc_core.
 * assumes the bench commands regeneration, overtemperature and feedback faults.
 */
`timescale 1ns/10ps

module smc_bridge_model
(
	// clock and switching state
	input wire logic clk,
	input wire logic pwm_enable,
	// scenario commands
	input wire logic cmd_regen,
	input wire logic cmd_hot,
	input wire logic cmd_pfb_bad,
	input wire logic cmd_slow,
	// bridge pins and measurements
	output logic regen,
	output logic switch_overtemp_alarm,
	output logic pulse_feedback_bad,
	output logic signed [15:0] deadtime_err,
	output logic signed [15:0] current_osc
);
	int seed = 32'h00f0; // own stream, repeatable
	int r;
	logic [2:0] lag = 3'h0; // slow sensor delays the alarm three cycles

	initial
	begin
		{regen, switch_overtemp_alarm, pulse_feedback_bad} = 3'h0;
		deadtime_err = 16'sh0000;
		current_osc = 16'sh0000;
	end

	// pins follow commands; without pulses there is nothing to measure or ring
	always @(posedge clk)
	begin
		r = $random(seed);
		lag <= {lag[1:0], cmd_hot};
		regen <= cmd_regen;
		switch_overtemp_alarm <= cmd_slow ? lag[2] : cmd_hot;
		pulse_feedback_bad <= cmd_pfb_bad;
		deadtime_err <= pwm_enable ? r[15:0] : 16'sh0000;
		current_osc <= pwm_enable ? r[31:16] : 16'sh0000;
	end
endmodule : smc_bridge_model

// file: testbench/smc_core_checker.sv
/*
 * concurrent checks on the ports of smc_core, bound into every instance.
 * assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/10ps

module smc_checker
	import smc_pkg::*;
#(
	parameter int RPM_PER_HZ = SMC_RPM_PER_HZ
)
(
	// clock, reset and register port
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	// pins and drive path
	input wire logic dc_braking,
	input wire logic pulse_feedback_bad,
	input wire logic signed [15:0] deadtime_err,
	input wire logic signed [15:0] current_osc,
	input wire logic [15:0] out_speed,
	input wire logic pwm_enable,
	input wire logic signed [15:0] deadtime_corr,
	input wire logic signed [15:0] stab_corr,
	input wire logic scalar_active,
	input wire logic pulse_feedback_fault
);
	// lowest speed that still reaches 0.1 Hz, rounded up
	localparam logic [15:0] CUT = 16'((RPM_PER_HZ * SMC_CUT_FREQ_DHZ + 9) / 10);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// a control type write not followed by a second one
	sequence s_type_write;
		wr && addr == SMC_CTL_TYPE ##1 !(wr && addr == SMC_CTL_TYPE);
	endsequence
	// a read strobe and its data cycle
	sequence s_read(logic [4:0] a);
		rd && addr == a ##1 1'b1;
	endsequence

	a_read_idle:
		assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data not zero outside the data cycle");
	a_option_mask:
		assert property (s_read(SMC_OPTION_BITS) |-> rdata[15:4] == 12'h000)
		else $error("option word wider than four bits");
	a_clear_reads_zero:
		assert property (s_read(SMC_IRQ_CLR) |-> rdata == 16'h0000)
		else $error("write-only clear word read back");
	a_deadtime_pass:
		assert property (deadtime_corr != 16'sh0000 |-> deadtime_corr == $past(deadtime_err))
		else $error("dead-time correction not the measured error");
	a_stab_gain:
		assert property (stab_corr != 16'sh0000 |-> stab_corr == -($past(current_osc) >>> SMC_STAB_SHIFT))
		else $error("damping term has the wrong gain");
	a_pwm_cut_speed:
		assert property (out_speed >= CUT |-> pwm_enable)
		else $error("pulses cut above the minimum frequency");
	a_pwm_brake_only:
		assert property (pwm_enable && out_speed < CUT
			|-> $past(dc_braking, 2) || $past(dc_braking, 3) || $past(dc_braking, 4))
		else $error("pulses below minimum frequency without braking");
	a_pfb_cause:
		assert property ($rose(pulse_feedback_fault)
			|-> $past(pulse_feedback_bad, 2) || $past(pulse_feedback_bad, 3) || $past(pulse_feedback_bad, 4))
		else $error("feedback fault raised without a bad feedback pin");
	a_type_scalar:
		assert property (s_type_write |=> scalar_active == ($past(wdata, 2) < SMC_CTL_VECTOR))
		else $error("scalar mode flag does not follow control type");
	a_type_hold:
		assert property ($changed(scalar_active) |-> $past(wr) || $past(wr, 2))
		else $error("scalar mode flag changed without a write");
endmodule : smc_checker

bind smc_core smc_checker #(.RPM_PER_HZ(RPM_PER_HZ)) u_smc_checker (.*);

// file: testbench/tb_scalar_motor_curve_control.sv
/*
 * self-checking bench for smc_core, bridge model on the far side.
 * assumes smc_pkg, the design and the bound checker are compiled first.
 */
`timescale 1ns/10ps

module tb_scalar_motor_curve_control
	import smc_pkg::*;
;
	localparam int CUT = (SMC_RPM_PER_HZ * SMC_CUT_FREQ_DHZ + 9) / 10;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0, rd = 1'b0, dc_braking = 1'b0;
	logic [15:0] speed_ref = 16'h0000;
	logic signed [15:0] slip_comp_in = 16'sh0000;
	logic cmd_regen = 1'b0, cmd_hot = 1'b0, cmd_pfb_bad = 1'b0, cmd_slow = 1'b0;
	logic [15:0] rdata, volt_amp, out_speed, sw_freq_eff;
	logic pwm_enable, scalar_active, pulse_feedback_fault, config_error_status, irq;
	logic regen, switch_overtemp_alarm, pulse_feedback_bad;
	logic signed [15:0] deadtime_err, current_osc, deadtime_corr, stab_corr, dt_q, osc_q;
	int err_total = 0, num_checks = 0, seed = 32'h00f0, s, sl, c;
	logic [3:0] opt;
	logic rg, hot, bad, pf = 1'b0;
	// reset words in address order, then the curve-check cases
	logic [15:0] rst_tab [12] = '{SMC_OPTION_RST, SMC_SPD_LO_RST, SMC_SPD_HI_RST, SMC_BOOST_V_RST,
		SMC_MAX_V_RST, SMC_MID_V_RST, SMC_LOW_V_RST, SMC_FW_SPD_RST, SMC_MID_SPD_RST,
		SMC_LOW_SPD_RST, SMC_SW_FREQ_RST, SMC_CTL_TYPE_RST};
	logic [4:0] ca [4] = '{SMC_LOW_SPD, SMC_MID_SPD, SMC_LOW_SPD, SMC_LOW_SPD};
	logic [15:0] cv [4] = '{16'h0258, 16'h0384, 16'h000A, 16'h002D};
	logic [15:0] cr [4] = '{16'h012C, 16'h0258, 16'h012C, 16'h012C};
	logic ce [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

	always #5 clk = ~clk;

	// every port meets the bench signal of the same name
	smc_core dut (.*);

	smc_bridge_model u_bridge (.*);

	// measurements as the design saw them at the last edge
	always @(posedge clk)
	begin
		dt_q <= deadtime_err;
		osc_q <= current_osc;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wreg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg

	// data is only valid in the cycle after the strobe
	task automatic rchk(input string what, input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(what, exp, rdata);
	endtask : rchk

	task automatic drive(input int sp, input int slip, input int n);
		@(posedge clk);
		speed_ref <= 16'(sp);
		slip_comp_in <= 16'(slip);
		repeat (n) @(posedge clk);
		#1;
	endtask : drive

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	function automatic int clampv(input int sp);
		return sp < SMC_SPD_LO_RST ? SMC_SPD_LO_RST : (sp > SMC_SPD_HI_RST ? SMC_SPD_HI_RST : sp);
	endfunction : clampv

	// bench curve (0,100) (300,250) (600,550) (900,1000), flat beyond
	function automatic int exp_volt(input int v);
		if (v >= 900)
			return 1000;
		if (v >= 600)
			return 550 + (v - 600) * 3 / 2;
		if (v >= 300)
			return 250 + v - 300;
		return 100 + v / 2;
	endfunction : exp_volt

	// whole sequence needs a few thousand cycles; a hang ends here
	initial
	begin
		#400000;
		err_total++;
		wrap_up();
	end

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 12; i++)
			rchk("reset word", 5'(i), rst_tab[i]);
		rchk("write only", SMC_IRQ_CLR, 16'h0000);
		rchk("unmapped", 5'h1F, 16'h0000);
		drive(900, 0, 2);
		chk("default curve", 16'h01F4, volt_amp);
		for (int t = 0; t < 5; t++)
		begin
			wreg(SMC_CTL_TYPE, 16'(t));
			repeat (2) @(posedge clk);
			#1 chk("scalar mode", 16'(t < 3), scalar_active);
		end
		wreg(SMC_CTL_TYPE, 16'h0000);
		for (int i = 0; i < 16; i++)
		begin
			wreg(SMC_OPTION_BITS, 16'(i) | 16'hFFF0);
			rchk("option word", SMC_OPTION_BITS, 16'(i));
		end
		// order keeps the points rising while they move
		wreg(SMC_BOOST_V, 16'h0064);
		wreg(SMC_LOW_V, 16'h00FA);
		wreg(SMC_MID_V, 16'h0226);
		wreg(SMC_LOW_SPD, 16'h012C);
		wreg(SMC_MID_SPD, 16'h0258);
		wreg(SMC_FW_SPD, 16'h0384);
		wreg(SMC_IRQ_EN, 16'h0007);
		// last case lies exactly on the slope limit and must pass
		for (int i = 0; i < 4; i++)
		begin
			wreg(SMC_IRQ_CLR, 16'h0007);
			wreg(ca[i], cv[i]);
			repeat (3) @(posedge clk);
			#1 chk("config error", 16'(ce[i]), config_error_status);
			chk("error irq", 16'(ce[i]), irq);
			wreg(ca[i], cr[i]);
		end
		wreg(SMC_IRQ_EN, 16'h0000);
		wreg(SMC_IRQ_CLR, 16'h0007);
		wreg(SMC_LOW_SPD, 16'h0258);
		repeat (3) @(posedge clk);
		#1 chk("masked irq", 16'h0000, irq);
		rchk("sticky event", SMC_IRQ_STAT, 16'h0001);
		wreg(SMC_LOW_SPD, 16'h012C);
		wreg(SMC_SPD_LO, 16'h0000);
		for (int sp = 0; sp <= CUT; sp++)
		begin
			drive(sp, 0, 2);
			chk("pwm cut", 16'(sp >= CUT), pwm_enable);
		end
		@(posedge clk);
		dc_braking <= 1'b1;
		drive(0, 0, 5);
		chk("pwm braking", 16'h0001, pwm_enable);
		@(posedge clk);
		dc_braking <= 1'b0;
		wreg(SMC_SPD_LO, SMC_SPD_LO_RST);
		// pins settle before the option word changes, so the fault latch is predictable
		for (int n = 0; n < 200; n++)
		begin
			opt = n < 16 ? 4'(n) : 4'($random(seed));
			{rg, hot, bad} = 3'($random(seed));
			s = 2 * ($random(seed) & 32'h3FF);
			sl = $random(seed) % 40;
			@(posedge clk);
			cmd_regen <= rg;
			cmd_hot <= hot;
			cmd_pfb_bad <= bad;
			cmd_slow <= 1'($random(seed));
			repeat (10) @(posedge clk);
			wreg(SMC_OPTION_BITS, {12'h000, opt});
			drive(s, sl, 3);
			c = clampv(s);
			pf = opt[1] & (pf | bad);
			chk("out speed", 16'(c + (rg && !opt[0] ? 0 : sl)), out_speed);
			chk("voltage", 16'(exp_volt(c)), volt_amp);
			chk("dead time", opt[1] ? dt_q : 16'sh0000, deadtime_corr);
			chk("damping", opt[2] ? -(osc_q >>> SMC_STAB_SHIFT) : 16'sh0000, stab_corr);
			chk("switching", opt[3] && hot ? SMC_SW_FREQ_RST >> 1 : SMC_SW_FREQ_RST, sw_freq_eff);
			chk("pulse fault", 16'(pf), pulse_feedback_fault);
		end
		wrap_up();
	end
endmodule : tb_scalar_motor_curve_control
